// ---- hdl/lcp_pin_slice.sv ----
// one port's pin drivers, registered, with asynchronous reset tristate
module lcp_pin_slice #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_OE = '0,
  parameter logic [W-1:0] RST_O = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control bundle
  lcp_pin_if.slice pif
);
  // output data, reset value is a constant per port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pif.pin_o <= RST_O;
    end else begin
      pif.pin_o <= pif.out_val;
    end
  end
  // output enable: forced drive beats direction, forbidden drive beats both
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pif.pin_oe <= RST_OE;
    end else begin
      pif.pin_oe <= (pif.dir | pif.force_out) & ~pif.force_in;
    end
  end
  // pull-up only where not driving, or held on by jtag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pif.pin_pu <= '0;
    end else begin
      pif.pin_pu <= (pif.pu & ~((pif.dir | pif.force_out) & ~pif.force_in)) | pif.pu_force;
    end
  end
endmodule : lcp_pin_slice

// ---- hdl/lcp_top.sv ----
// legacy compatibility port and reset logic, with avalon register slave
// offsets, field positions and reset values
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`include "lcp_regs.svh"
module lcp_top #(
  parameter int PW = 8,
  parameter int GW = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // reset cause inputs and fuse
  input wire logic legacy_compat_fuse,
  input wire logic ext_reset_seen,
  input wire logic por_seen,
  // tap state from the jtag controller
  input wire logic tap_shift,
  input wire logic tdo_data,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // port pins, a..f eight bits, g five bits
  output logic [6*PW-1:0] port_o,
  output logic [6*PW-1:0] port_oe,
  output logic [6*PW-1:0] port_pu,
  output logic [GW-1:0] portg_o,
  output logic [GW-1:0] portg_oe,
  output logic [GW-1:0] portg_pu,
  output logic tdo_o,
  output logic tdo_oe,
  // mode status to the rest of the chip
  output logic legacy_mode,
  output logic ext_space_en,
  output logic usart_count2,
  output logic usart_sync_ok,
  output logic [11:0] baud_mask,
  output logic timer_dual3,
  output logic twi_boot_trim_en,
  output logic addr_release_en,
  output logic wdt_timed_seq,
  output logic ext_int_edge_ok,
  output logic [1:0] rx_depth
);
  // mode register, sampled at reset release
  logic legacy_r;
  logic sampled_r;
  // mode in force: the live fuse until captured, so reset pins follow it
  logic mode_leg;
  // bus fsm
  lcp_pkg::lcp_bus_e bus_r;
  // per-port registers: out, dir, pull-up
  logic [PW-1:0] out_r [7];
  logic [PW-1:0] dir_r [7];
  logic [PW-1:0] pu_r [7];
  logic [1:0] ctrl_r;
  logic [7:0] rstc_r;
  logic [31:0] rd_nxt;
  logic [2:0] sel;
  logic hit_port;
  logic [7:0] rstc_mask;
  logic wr_go;

  // fuse capture once
  // async reset loads constant; the strap is caught on first clocked edge
  // after release, default legacy; port C follows the live fuse until then
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      legacy_r <= 1'b1;
      sampled_r <= 1'b0;
    end else if (!sampled_r) begin
      legacy_r <= legacy_compat_fuse;
      sampled_r <= 1'b1;
    end
  end

  // fuse decides until capture
  // no clock is needed for the reset pin state, so the strap itself rules then
  assign mode_leg = sampled_r ? legacy_r : legacy_compat_fuse;

  // port index decode, offsets 0x10..0x28 step four
  always_comb begin
    sel = 3'h0;
    hit_port = 1'b0;
    case (avs_address)
      `LCP_OFF_PORTA: begin sel = 3'h0; hit_port = 1'b1; end
      `LCP_OFF_PORTB: begin sel = 3'h1; hit_port = 1'b1; end
      `LCP_OFF_THIRD_PORT_OUTPUT: begin sel = 3'h2; hit_port = 1'b1; end
      `LCP_OFF_PORTD: begin sel = 3'h3; hit_port = 1'b1; end
      `LCP_OFF_PORTE: begin sel = 3'h4; hit_port = 1'b1; end
      `LCP_OFF_PORTF: begin sel = 3'h5; hit_port = 1'b1; end
      `LCP_OFF_PORTG: begin sel = 3'h6; hit_port = 1'b1; end
      default: begin sel = 3'h0; hit_port = 1'b0; end
    endcase
  end

  assign rstc_mask = legacy_r ? `LCP_RSTC_MASK_LEGACY : `LCP_RSTC_MASK_NORMAL;

  // bus handshake: two wait cycles, then answer; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_r <= lcp_pkg::LCP_IDLE;
    end else begin
      case (bus_r)
        lcp_pkg::LCP_IDLE: begin
          if (avs_read || avs_write) begin
            bus_r <= lcp_pkg::LCP_WAIT;
          end
        end
        lcp_pkg::LCP_WAIT: bus_r <= lcp_pkg::LCP_DONE;
        lcp_pkg::LCP_DONE: bus_r <= lcp_pkg::LCP_IDLE;
        default: bus_r <= lcp_pkg::LCP_IDLE;
      endcase
    end
  end

  // waitrequest low for exactly the cycle spent in DONE
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_r == lcp_pkg::LCP_WAIT);
    end
  end
  // write commits on the edge where waitrequest is seen low
  assign wr_go = avs_write && !avs_waitrequest;

  // read mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_port) begin
      rd_nxt = {8'h00, pu_r[sel], dir_r[sel], out_r[sel]};
    end else if (avs_address == `LCP_OFF_CTRL) begin
      rd_nxt = {30'h0, ctrl_r};
    end else if (avs_address == `LCP_OFF_STAT) begin
      rd_nxt = {31'h0, legacy_r};
    end else if (avs_address == `LCP_OFF_RSTC) begin
      rd_nxt = {24'h0, rstc_r};
    end
  end

  // read data registered on the same edge that waitrequest falls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_r == lcp_pkg::LCP_WAIT) begin
      avs_readdata <= rd_nxt;
    end
  end

  // control register: adc enable, jtag enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 2'b10;
    end else if (wr_go && avs_address == `LCP_OFF_CTRL) begin
      ctrl_r <= avs_writedata[1:0];
    end
  end

  // reset cause flags; hardware set beats software clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rstc_r <= 8'h00;
    end else begin
      rstc_r <= ((wr_go && avs_address == `LCP_OFF_RSTC) ? (rstc_r & ~avs_writedata[7:0])
                 : rstc_r)
                | ({6'h0, ext_reset_seen, por_seen} & rstc_mask);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 7; i++) begin
        out_r[i] <= '0;
        dir_r[i] <= '0;
        pu_r[i] <= '0;
      end
    end else if (wr_go && hit_port) begin
      out_r[sel] <= avs_writedata[PW-1:0];
      dir_r[sel] <= avs_writedata[`LCP_DIR_SH +: PW];
      pu_r[sel] <= avs_writedata[`LCP_PU_SH +: PW];
    end
  end

  // pin slices; reset values tristate every port but C, which legacy mode drives through reset
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gp
      lcp_pin_if #(.W(PW)) pif ();
      assign pif.out_val = out_r[g];
      assign pif.dir = dir_r[g];
      assign pif.pu = pu_r[g];
      if (g == 2) begin : gc
        assign pif.force_out = {PW{mode_leg}};
        assign pif.force_in = '0;
        assign pif.pu_force = '0;
      end else if (g == 5) begin : gf
        // legacy or adc use keeps port F input
        assign pif.force_out = '0;
        assign pif.force_in = {PW{mode_leg | ctrl_r[`LCP_CTRL_ADC_BIT]}};
        // pull-ups on TDI bit7, TMS bit5, TCK bit4
        assign pif.pu_force = {ctrl_r[`LCP_CTRL_JTAG_BIT], 1'b0,
                               {2{ctrl_r[`LCP_CTRL_JTAG_BIT]}}, 4'h0};
      end else begin : gn
        assign pif.force_out = '0;
        assign pif.force_in = '0;
        assign pif.pu_force = '0;
      end
      lcp_pin_slice #(.W(PW), .RST_OE('0), .RST_O('0)) u_slice (
        .ref_clk(ref_clk),
        .rst(rst),
        .pif(pif.slice)
      );
      assign port_o[g*PW +: PW] = pif.pin_o;
      // held through reset
      // forced drive and jtag pull-ups bypass the reset flops, no clock needed
      assign port_oe[g*PW +: PW] = pif.pin_oe | pif.force_out;
      assign port_pu[g*PW +: PW] = pif.pin_pu | pif.pu_force;
    end
  endgenerate

  // port G: async reset sets strobes 0,1 high in either mode, enables tristate
  lcp_pin_if #(.W(GW)) gif ();
  assign gif.out_val = mode_leg ? `LCP_PG_LEGACY_RST : out_r[6][GW-1:0];
  assign gif.dir = dir_r[6][GW-1:0];
  assign gif.pu = pu_r[6][GW-1:0];
  // legacy drives strobes bit0..2, bits 3,4 oscillator
  assign gif.force_out = mode_leg ? 5'h07 : 5'h00;
  assign gif.force_in = mode_leg ? 5'h18 : 5'h00;
  assign gif.pu_force = '0;
  // normal mode is a plain 5-bit port via dir
  lcp_pin_slice #(.W(GW), .RST_OE('0), .RST_O('0)) u_gslice (
    .ref_clk(ref_clk),
    .rst(rst),
    .pif(gif.slice)
  );

  // reset preset: constant 1,1,0 on output value under reset
  // the enable follows the mode after the first edge; reset itself is tristate
  // because a flop may not load the mode asynchronously
  assign portg_o = gif.pin_o | ({GW{rst}} & `LCP_PG_LEGACY_RST);
  assign portg_oe = gif.pin_oe;
  assign portg_pu = gif.pin_pu;

  // tdo drives only in shift states
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_o <= tdo_data;
      tdo_oe <= tap_shift & ctrl_r[`LCP_CTRL_JTAG_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      legacy_mode <= 1'b1;
      ext_space_en <= 1'b0;
      usart_count2 <= 1'b0;
      usart_sync_ok <= 1'b0;
      baud_mask <= `LCP_BAUD_MASK_LEGACY;
      timer_dual3 <= 1'b0;
      twi_boot_trim_en <= 1'b0;
      addr_release_en <= 1'b0;
      wdt_timed_seq <= 1'b0;
      ext_int_edge_ok <= 1'b0;
      rx_depth <= `LCP_RX_DEPTH_LEGACY;
    end else begin
      legacy_mode <= legacy_r;
      ext_space_en <= !legacy_r;
      usart_count2 <= !legacy_r;
      usart_sync_ok <= !legacy_r;
      baud_mask <= legacy_r ? `LCP_BAUD_MASK_LEGACY : 12'hFFF;
      timer_dual3 <= !legacy_r;
      twi_boot_trim_en <= !legacy_r;
      addr_release_en <= !legacy_r;
      wdt_timed_seq <= !legacy_r;
      ext_int_edge_ok <= !legacy_r;
      rx_depth <= legacy_r ? `LCP_RX_DEPTH_LEGACY : `LCP_RX_DEPTH_NORMAL;
    end
  end

  // checks
  property p_tdo_quiet;
    @(posedge ref_clk) disable iff (rst) !$past(tap_shift) |-> !tdo_oe;
  endproperty
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo driven outside shift");
  property p_third_port_output_out;
    @(posedge ref_clk) mode_leg |-> &port_oe[2*PW +: PW];
  endproperty
  a_third_port_output_out: assert property (p_third_port_output_out) else $error("port c not driving");
  property p_portf_in;
    @(posedge ref_clk) disable iff (rst) $past(legacy_r) |-> port_oe[5*PW +: PW] == '0;
  endproperty
  a_portf_in: assert property (p_portf_in) else $error("port f driving in legacy");
  property p_reset_tri;
    @(posedge ref_clk) rst |->
      port_oe == {{(3*PW){1'b0}}, {PW{mode_leg}}, {(2*PW){1'b0}}} && portg_oe == '0;
  endproperty
  a_reset_tri: assert property (p_reset_tri) else $error("pin driven during reset");
  property p_fuse_hold;
    @(posedge ref_clk) disable iff (rst) sampled_r |=> $stable(legacy_r);
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("mode changed after capture");
  property p_rstc_mask;
    @(posedge ref_clk) disable iff (rst) legacy_r |-> rstc_r[7:2] == 6'h00 || !$past(legacy_r);
  endproperty
  a_rstc_mask: assert property (p_rstc_mask) else $error("extra reset cause flag");
  property p_jtag_pu;
    @(posedge ref_clk)
      ctrl_r[`LCP_CTRL_JTAG_BIT] |-> port_pu[5*PW+7] && port_pu[5*PW+5] && port_pu[5*PW+4];
  endproperty
  a_jtag_pu: assert property (p_jtag_pu) else $error("jtag pull-up lost");
  sequence s_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  property p_ext_off;
    @(posedge ref_clk) disable iff (rst) s_wait ##1 legacy_r |-> !ext_space_en;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("extended space on in legacy");
endmodule : lcp_top

// ---- shared/lcp_pin_if.sv ----
// per-port pin control bundle between the top and the pin slice
interface lcp_pin_if #(parameter int W = 8);
  logic [W-1:0] out_val;   // register output value
  logic [W-1:0] dir;       // register direction
  logic [W-1:0] pu;        // register pull-up enable
  logic [W-1:0] force_out; // mode forces drive
  logic [W-1:0] force_in;  // mode forbids drive
  logic [W-1:0] pu_force;  // pull-up held on
  logic [W-1:0] pin_o;
  logic [W-1:0] pin_oe;
  logic [W-1:0] pin_pu;
  modport ctl (output out_val, dir, pu, force_out, force_in, pu_force,
               input pin_o, pin_oe, pin_pu);
  modport slice (input out_val, dir, pu, force_out, force_in, pu_force,
                 output pin_o, pin_oe, pin_pu);
endinterface : lcp_pin_if

// ---- shared/lcp_pkg.sv ----
// types shared by the legacy compat port block
package lcp_pkg;
  typedef enum logic [1:0] {
    LCP_IDLE = 2'b00,
    LCP_WAIT = 2'b01,
    LCP_DONE = 2'b10
  } lcp_bus_e;
  typedef logic [7:0] lcp_byte_t;
endpackage : lcp_pkg

// ---- shared/lcp_regs.svh ----
// register offsets, field positions, reset values for the legacy compat port block
`ifndef LCP_REGS_SVH
`define LCP_REGS_SVH
`define LCP_EXT_LO 8'h60
`define LCP_EXT_HI 8'hFF
`define LCP_OFF_CTRL 8'h00
`define LCP_OFF_STAT 8'h04
`define LCP_OFF_RSTC 8'h08
`define LCP_OFF_PORTA 8'h10
`define LCP_OFF_PORTB 8'h14
`define LCP_OFF_THIRD_PORT_OUTPUT 8'h18
`define LCP_OFF_PORTD 8'h1C
`define LCP_OFF_PORTE 8'h20
`define LCP_OFF_PORTF 8'h24
`define LCP_OFF_PORTG 8'h28
`define LCP_DIR_SH 8
`define LCP_PU_SH 16
`define LCP_CTRL_ADC_BIT 0
`define LCP_CTRL_JTAG_BIT 1
`define LCP_RSTC_EXT_BIT 1
`define LCP_RSTC_POR_BIT 0
`define LCP_RSTC_MASK_LEGACY 8'h03
`define LCP_RSTC_MASK_NORMAL 8'h1F
`define LCP_PG_LEGACY_RST 5'h03
`define LCP_BAUD_MASK_LEGACY 12'h0FF
`define LCP_RX_DEPTH_NORMAL 2'h2
`define LCP_RX_DEPTH_LEGACY 2'h1
`define LCP_WAIT_CYCLES 2'h1
`endif

// ---- testbench/lcp_board.sv ----
// board side of the port pins: pad levels
module lcp_board (
  // clock
  input wire logic ref_clk,
  // pin drivers from the block
  input wire logic [47:0] port_o,
  input wire logic [47:0] port_oe,
  input wire logic [47:0] port_pu,
  // levels on the pads
  output logic [47:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating pad wanders, so it never passes for a level
  logic [47:0] float_r = 48'h0;
  always @(posedge ref_clk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      pad[i] = port_oe[i] ? port_o[i] : (port_pu[i] ? 1'b1 : float_r[i]);
    end
  end
endmodule : lcp_board

// ---- testbench/lcp_top_tb_top.sv ----
// self-checking bench for the legacy compat port block
`include "lcp_regs.svh"
module lcp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and straps
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic fuse = 1'b1;
  logic ext_seen = 1'b0;
  logic por_seen = 1'b0;
  logic tap_shift = 1'b0;
  logic tdo_data = 1'b0;
  // avalon master side
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rv;
  logic wreq;
  // pins, pads and mode outputs
  logic [47:0] po, poe, ppu, pad, mw;
  logic [4:0] go, goe, gpu;
  logic tdo_o, tdo_oe, lm, xe, u2, us, d3, tw, ar, ws, ee;
  logic [11:0] baud;
  logic [1:0] rxd;
  int fails = 0;
  int n_compared = 0;
  // expected mode words, legacy and normal
  localparam logic [47:0] MW_LEG = {25'h0, 4'h8, `LCP_BAUD_MASK_LEGACY, 5'h00,
    `LCP_RX_DEPTH_LEGACY};
  localparam logic [47:0] MW_NRM = {25'h0, 4'h7, 12'hFFF, 5'h1F, `LCP_RX_DEPTH_NORMAL};
  assign mw = {25'h0, lm, xe, u2, us, baud, d3, tw, ar, ws, ee, rxd};

  // 200 MHz clock
  initial forever #2.5 ref_clk = ~ref_clk;

  lcp_top i_lcp_top (
    .ref_clk(ref_clk), .rst(rst), .legacy_compat_fuse(fuse),
    .ext_reset_seen(ext_seen), .por_seen(por_seen),
    .tap_shift(tap_shift), .tdo_data(tdo_data),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .port_o(po), .port_oe(poe), .port_pu(ppu),
    .portg_o(go), .portg_oe(goe), .portg_pu(gpu),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .legacy_mode(lm), .ext_space_en(xe),
    .usart_count2(u2), .usart_sync_ok(us), .baud_mask(baud),
    .timer_dual3(d3), .twi_boot_trim_en(tw), .addr_release_en(ar),
    .wdt_timed_seq(ws), .ext_int_edge_ok(ee), .rx_depth(rxd)
  );

  lcp_board i_lcp_board (
    .ref_clk(ref_clk), .port_o(po), .port_oe(poe), .port_pu(ppu), .pad(pad)
  );

  // verdict, the single end of the run
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // compare any pin or value word
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    // a slave that never answers ends the run
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  // read and compare a register
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk({16'h0, rv}, {16'h0, e});
  endtask : chk_rd

  // write then let the pin flops follow
  task automatic wr_set(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge ref_clk);
  endtask : wr_set

  // hold reset 8 cycles, release with the strap, wait past mode sampling
  task automatic rel(input logic f);
    repeat (8) @(posedge ref_clk);
    fuse <= f;
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : rel

  // main sequence
  initial begin
    // reset rises at time zero as an event, so every flop sees it
    rst <= 1'b1;
    @(posedge ref_clk);
    chk({43'h0, go}, {43'h0, `LCP_PG_LEGACY_RST});
    rel(1'b1);
    // legacy mode as shipped
    chk(mw, MW_LEG);
    chk(poe, 48'h0000_00FF_0000);
    chk({38'h0, goe, go}, {38'h0, 5'h07, `LCP_PG_LEGACY_RST});
    chk(ppu, 48'hB000_0000_0000);
    chk_rd(`LCP_OFF_CTRL, 32'h2);
    chk_rd(`LCP_OFF_STAT, 32'h1);
    // reset cause flags, then write-one clear
    ext_seen <= 1'b1;
    por_seen <= 1'b1;
    @(posedge ref_clk);
    ext_seen <= 1'b0;
    por_seen <= 1'b0;
    @(posedge ref_clk);
    chk_rd(`LCP_OFF_RSTC, 32'h3);
    bus(1'b1, `LCP_OFF_RSTC, 32'h3);
    chk_rd(`LCP_OFF_RSTC, 32'h0);
    // unused bits written as zero
    wr_set(`LCP_OFF_THIRD_PORT_OUTPUT, 32'h0000_005A);
    wr_set(`LCP_OFF_PORTF, 32'h0000_FF00);
    wr_set(`LCP_OFF_PORTA, 32'h00F0_0F0A);
    chk(poe, 48'h0000_00FF_000F);
    chk({32'h0, po[23:16], pad[7:0]}, {32'h0, 8'h5A, 8'hFA});
    chk({40'h0, ppu[7:0]}, 48'hF0);
    chk_rd(`LCP_OFF_PORTA, 32'h00F0_0F0A);
    chk_rd(`LCP_EXT_LO, 32'h0);
    chk_rd(8'h2C, 32'h0);
    // tdo drives only in shift states
    tap_shift <= 1'b1;
    tdo_data <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({46'h0, tdo_oe, tdo_o}, 48'h3);
    tap_shift <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({47'h0, tdo_oe}, 48'h0);
    // strap moves, mode must not
    fuse <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(mw, MW_LEG);
    // reset from legacy, seen before any clock edge
    fuse <= 1'b1;
    rst <= 1'b1;
    #1;
    chk(poe, 48'h0000_00FF_0000);
    chk(ppu, 48'hB000_0000_0000);
    chk({43'h0, go}, {43'h0, `LCP_PG_LEGACY_RST});
    rel(1'b0);
    // normal mode
    chk(mw, MW_NRM);
    wr_set(`LCP_OFF_CTRL, 32'h0);
    chk(ppu, 48'h0);
    wr_set(`LCP_OFF_PORTG, 32'h0018_070A);
    chk({33'h0, gpu, goe, go}, {33'h0, 5'h18, 5'h07, 5'h0A});
    wr_set(`LCP_OFF_PORTF, 32'h0000_FF3C);
    wr_set(`LCP_OFF_THIRD_PORT_OUTPUT, 32'h0000_0000);
    chk(poe, 48'hFF00_0000_0000);
    chk({40'h0, pad[47:40]}, 48'h3C);
    wr_set(`LCP_OFF_CTRL, 32'h1);
    chk(poe, 48'h0);
    wr_set(`LCP_OFF_CTRL, 32'h0);
    // reset from normal mode, seen before any clock edge
    rst <= 1'b1;
    #1;
    chk({poe[42:0], goe}, 48'h0);
    chk({43'h0, poe[47:43]}, 48'h0);
    rel(1'b1);
    chk(mw, MW_LEG);
    report_and_stop();
  end

  // watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end
endmodule : lcp_top_tb_top
